// ==== sarc_params.svh ====
// timing and width constants for the sar conversion control
`ifndef SARC_PARAMS_SVH
`define SARC_PARAMS_SVH
`define SARC_RES_BITS 12
`define SARC_CLK_MHZ 200
`define SARC_CONV_MAX_MHZ 16
`define SARC_SAMPLE_KSPS 1000
`define SARC_WAKE_US 10
`define SARC_CLK_PER_SAMPLE 16
`define SARC_FIFO_DEPTH 16
`endif

// ==== sarc_pkg.sv ====
// types shared by the sar conversion control
package sarc_pkg;
    typedef enum logic [1:0] {
        SARC_WAKE = 2'b00,
        SARC_IDLE = 2'b01,
        SARC_CONV = 2'b10,
        SARC_DONE = 2'b11
    } sarc_state_t;
    typedef struct packed {
        logic single;
        logic enable;
        logic start;
    } sarc_ctrl_t;
endpackage

// ==== sarc_fifo.sv ====
// result fifo with valid/ready on both sides and registered read data
`timescale 1ns/1ps
module sarc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire do_push = in_valid_i && in_ready_o;
    wire mem_has = count != '0;
    // the output register counts as one more slot in front of the array
    wire do_load = mem_has && (!out_valid_o || out_ready_i);
    wire do_drop = out_valid_o && out_ready_i && !do_load;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else
        begin
            if (do_push)
            begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (do_load)
            begin
                out_data_o <= mem[rd_ptr];
                rd_ptr <= AW'(rd_ptr + 1'b1);
                out_valid_o <= 1'b1;
            end
            else if (do_drop)
                out_valid_o <= 1'b0;
            count <= (AW+1)'(count + do_push - do_load);
            // ready is registered, so it leaves one slot spare for safety
            in_ready_o <= (AW+1)'(count + do_push - do_load)
                < (AW+1)'(DEPTH - 1);
        end
    end
endmodule

// ==== sarc_top.sv ====
// digital conversion control of a 12-bit successive-approximation adc
// Functional notes
// [R1] a conversion starts on the software start bit or the frame-start input.
// [R2] after power up or wake, no conversion starts until 10 us have passed.
// [R3] at completion a status bit sets and done stays high until result read.
// [R4] the single select bit picks continuous or one conversion per trigger.
// [R5] the conversion clock is sixteen times sample rate, at most 16 MHz; a continuous sample here takes 13 ticks, 169 clocks.
// [R6] bits are decided by binary search from msb down to lsb.
// [R7] results are 12 bits at up to 1 Msps, single-ended or differential.
// [R8] in continuous mode the frame-start input may be left unconnected.
// [R9] the done output can serve as an interrupt or dma request.
// [R10] in continuous mode dma collects results without cpu help.
// [R11] a start request during a running conversion is ignored.
`timescale 1ns/1ps
`include "sarc_params.svh"
module sarc_top
    import sarc_pkg::*;
#(
    parameter int RES_BITS = `SARC_RES_BITS,
    parameter int WAKE_CYCLES = (`SARC_WAKE_US * `SARC_CLK_MHZ),
    parameter int FIFO_DEPTH = `SARC_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire sarc_ctrl_t ctrl_i,
    input wire logic diff_mode_i,
    input wire logic wake_i,
    input wire logic frame_start_i,
    input wire logic comp_i,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic sample_o,
    output logic diff_o,
    output logic busy_o,
    output logic ready_o,
    output logic done_status_o,
    output logic conv_done_o,
    input wire logic read_i,
    output logic [RES_BITS-1:0] result_o,
    output logic result_valid_o
);
    // conversion clock enable, divider rounded up so the tick never runs
    // above the 16 MHz ceiling; this costs a little of the sample rate
    localparam int CONV_DIV = (`SARC_CLK_MHZ * 1000
        + `SARC_SAMPLE_KSPS * `SARC_CLK_PER_SAMPLE - 1) /
        (`SARC_SAMPLE_KSPS * `SARC_CLK_PER_SAMPLE);
    localparam int DIVW = $clog2(CONV_DIV + 1);
    localparam int WKW = $clog2(WAKE_CYCLES + 1);
    localparam int BW = $clog2(RES_BITS + 1);

    sarc_state_t state;
    sarc_state_t next_state;
    logic [DIVW-1:0] div_cnt;
    logic [WKW-1:0] wake_cnt;
    logic [BW-1:0] bit_idx;
    logic [RES_BITS-1:0] trial;
    logic [1:0] fs_sync;
    logic fs_prev;
    logic fs_pend;
    logic [1:0] wk_sync;
    logic [1:0] cmp_sync;
    logic fifo_in_ready;

    // pins are asynchronous to clk_i and get two flops each
    wire fs_lvl = fs_sync[1];
    wire fs_rise = fs_lvl && !fs_prev;
    wire conv_tick = div_cnt == DIVW'(CONV_DIV - 1); // see [R5]
    wire wake_over = wake_cnt == WKW'(WAKE_CYCLES);
    // continuous mode needs no frame-start, so an unconnected pin is harmless
    wire auto_go = ctrl_i.enable && !ctrl_i.single; // see [R4] [R8]
    wire trig_go = ctrl_i.start || fs_rise || fs_pend; // see [R1]
    wire go = (auto_go || trig_go) && fifo_in_ready;
    wire last_bit = bit_idx == '0;
    wire bit_keep = cmp_sync[1];
    // done stays until the reader takes the result; that is also dma request
    wire result_taken = result_valid_o && read_i; // see [R3] [R9]

    always_comb
    begin
        next_state = state;
        unique case (state)
            SARC_WAKE: if (wake_over) next_state = SARC_IDLE; // see [R2]
            SARC_IDLE: if (go && conv_tick) next_state = SARC_CONV;
            SARC_CONV: if (conv_tick && last_bit) next_state = SARC_DONE;
            SARC_DONE: next_state = SARC_IDLE;
        endcase
        if (wk_sync[1])
            next_state = SARC_WAKE;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fs_sync <= '0;
            fs_prev <= 1'b0;
            fs_pend <= 1'b0;
            wk_sync <= '0;
            cmp_sync <= '0;
        end
        else
        begin
            fs_sync <= {fs_sync[0], frame_start_i};
            fs_prev <= fs_lvl;
            wk_sync <= {wk_sync[0], wake_i};
            cmp_sync <= {cmp_sync[0], comp_i};
            // a one-cycle edge would mostly miss the tick, so it waits here
            if (state == SARC_IDLE && next_state == SARC_CONV)
                fs_pend <= 1'b0;
            else if (fs_rise && state == SARC_IDLE)
                fs_pend <= 1'b1; // see [R1] [R11]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= SARC_WAKE;
            div_cnt <= '0;
            wake_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            div_cnt <= conv_tick ? '0 : DIVW'(div_cnt + 1'b1);
            // the wait only counts once the sleep request has gone
            if (next_state != SARC_WAKE || state != SARC_WAKE || wk_sync[1])
                wake_cnt <= '0;
            else if (!wake_over)
                wake_cnt <= WKW'(wake_cnt + 1'b1); // see [R2]
        end
    end

    // successive approximation; start is only looked at in idle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bit_idx <= '0;
            trial <= '0;
            dac_code_o <= '0;
            sample_o <= 1'b0;
            diff_o <= 1'b0;
        end
        else if (state == SARC_IDLE && next_state == SARC_CONV)
        begin
            bit_idx <= BW'(RES_BITS - 1);
            trial <= '0;
            dac_code_o <= {1'b1, {(RES_BITS-1){1'b0}}}; // see [R6]
            sample_o <= 1'b1;
            diff_o <= diff_mode_i; // see [R7]
        end
        else if (state == SARC_CONV && conv_tick) // see [R11]
        begin
            sample_o <= 1'b0;
            // comparator high keeps the trial bit, then try the next one
            trial[bit_idx] <= bit_keep; // see [R6]
            if (!last_bit)
            begin
                bit_idx <= BW'(bit_idx - 1'b1);
                dac_code_o[bit_idx] <= bit_keep;
                dac_code_o[bit_idx - 1'b1] <= 1'b1;
            end
            else
                dac_code_o[bit_idx] <= bit_keep;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
            ready_o <= 1'b0;
            done_status_o <= 1'b0;
            conv_done_o <= 1'b0;
        end
        else
        begin
            busy_o <= next_state == SARC_CONV;
            ready_o <= next_state == SARC_IDLE;
            // set beats clear; the flag drops once the queue has run dry
            if (state == SARC_DONE)
                done_status_o <= 1'b1; // see [R3]
            else if (!conv_done_o && !result_valid_o)
                done_status_o <= 1'b0;
            // held through the fifo's load latency, so no gap before a read
            conv_done_o <= state == SARC_DONE // see [R3] [R9]
                || (conv_done_o || result_valid_o) && !result_taken;
        end
    end

    // results queue so dma can drain a continuous stream unattended
    sarc_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(state == SARC_DONE),
        .in_ready_o(fifo_in_ready),
        .in_data_i(trial),
        .out_valid_o(result_valid_o),
        .out_ready_i(read_i),
        .out_data_o(result_o)
    ); // see [R10]

    wake_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(state == SARC_WAKE) |-> (state == SARC_WAKE) [*8]) // see [R2]
        else $error("wake wait cut short");
    no_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == SARC_CONV && !(conv_tick && last_bit) && !wk_sync[1]
        |=> state == SARC_CONV) // see [R11]
        else $error("conversion disturbed");
    done_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == SARC_DONE |=> done_status_o && conv_done_o) // see [R3]
        else $error("completion not flagged");
    done_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done_o && !result_taken |=> conv_done_o) // see [R3] [R9]
        else $error("done dropped before read");
    msb_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == SARC_IDLE && next_state == SARC_CONV
        |=> bit_idx == BW'(RES_BITS - 1)) // see [R6]
        else $error("search not msb first");
    tick_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_tick |=> !conv_tick [*8] ##1 !conv_tick [*4]) // see [R5]
        else $error("conversion clock too fast");
    single_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == SARC_IDLE && ctrl_i.single && !ctrl_i.start && !fs_rise
        && !fs_pend |=> state != SARC_CONV) // see [R4] [R1]
        else $error("single mode ran untriggered");
    busy_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        busy_o == (state == SARC_CONV)) // see [R11]
        else $error("busy mismatch");
endmodule

// ==== sarc_reader_model.sv ====
// behavioural result reader standing in for the cpu or dma side
`timescale 1ns/1ps
module sarc_reader_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic read_o
);
    logic [1:0] pace;
    // at most every other cycle, so a valid that lags a pop is not taken twice
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pace <= 2'h0;
            read_o <= 1'b0;
        end
        else
        begin
            pace <= pace + 2'h1;
            read_o <= valid_i && !stall_i && !read_o
                && (!slow_i || pace == 2'h3);
        end
    end
endmodule

// ==== sarc_top_tb.sv ====
// self-checking bench for the sar conversion control
`timescale 1ns/1ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %s", $time, m); end end
module sarc_top_tb;
    import sarc_pkg::*;
    localparam int WAKE = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sarc_ctrl_t ctrl = '0;
    logic diff = 1'b0;
    logic wake = 1'b0;
    logic fs = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [11:0] vin = 12'h000;
    logic read, sample, diffo, busy, rdy, dstat, cdone, rvalid;
    logic [11:0] dac, res;
    logic [11:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int seed = 32'hddc21b24;
    int cyc = 0;
    // ideal comparator: keeps the trial bit while the input is not below it
    wire comp = (vin >= dac);
    always #2.5 clk_i = ~clk_i;
    sarc_top #(.WAKE_CYCLES(WAKE)) u_sarc_top (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ctrl_i(ctrl), .diff_mode_i(diff),
        .wake_i(wake), .frame_start_i(fs), .comp_i(comp),
        .dac_code_o(dac), .sample_o(sample), .diff_o(diffo),
        .busy_o(busy), .ready_o(rdy), .done_status_o(dstat),
        .conv_done_o(cdone), .read_i(read), .result_o(res),
        .result_valid_o(rvalid));
    sarc_reader_model u_sarc_reader_model (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .valid_i(rvalid), .stall_i(stall),
        .slow_i(slow), .read_o(read));
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (read && rvalid)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b0, 1'b1, "extra result")
            else
                `CHK(res, exp_q.pop_front(), "result")
        end
        if (cyc == 20000)
        begin
            n_fail++;
            $display("wrong value at %0t: run too long", $time);
            close_out();
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic until_ready();
        int k;
        for (k = 0; k < WAKE + 8 && rdy !== 1'b1; k++) settle(1);
        `CHK(k >= WAKE + 1 && k <= WAKE + 4, 1'b1, "wake wait")
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 600 && (exp_q.size() != 0 || rvalid); k++) settle(1);
        settle(4);
        `CHK(exp_q.size(), 0, "lost result")
        `CHK({cdone, dstat}, 2'b00, "flags after read")
    endtask
    task automatic convert(input logic [11:0] v, input logic hold);
        int k;
        realtime t0;
        @(posedge clk_i);
        vin <= v;
        diff <= v[0];
        ctrl.start <= 1'b1;
        stall <= hold;
        exp_q.push_back(v);
        for (k = 0; k < 40 && busy !== 1'b1; k++) settle(1);
        t0 = $realtime;
        `CHK({dac, sample, diffo}, {12'h800, 1'b1, v[0]}, "first")
        @(posedge clk_i);
        ctrl.start <= 1'b0;
        settle(20);
        // a second request mid-conversion must leave no trace
        ctrl.start <= 1'b1;
        settle(14);
        ctrl.start <= 1'b0;
        for (k = 0; k < 200 && cdone !== 1'b1; k++) settle(1);
        k = int'(($realtime - t0) / 5.0);
        // twelve ticks of at least 13 clocks each keep the tick <= 16 MHz
        `CHK(k >= 156 && k <= 170, 1'b1, "conversion length")
        if (hold)
        begin
            settle(40);
            `CHK({cdone, dstat}, 2'b11, "done held")
            stall <= 1'b0;
        end
        drain();
    endtask
    initial
    begin
        logic [11:0] v;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle(0);
        until_ready();
        $display("test reset wait done");
        ctrl.single <= 1'b1;
        for (int i = 0; i < 6; i++)
            convert(i == 0 ? 12'h000 : i == 1 ? 12'hfff
                : 12'($random(seed)), i == 2);
        $display("test software start done");
        v = 12'($random(seed));
        vin <= v;
        fs <= 1'b1;
        exp_q.push_back(v);
        settle(30);
        fs <= 1'b0;
        drain();
        $display("test frame start done");
        wake <= 1'b1;
        settle(6);
        `CHK(rdy, 1'b0, "ready in sleep")
        wake <= 1'b0;
        until_ready();
        $display("test wake done");
        stall <= 1'b1;
        v = 12'($random(seed));
        vin <= v;
        ctrl <= '{1'b0, 1'b1, 1'b0};
        settle(4000);
        `CHK({busy, rvalid, dstat}, 3'b011, "full fifo")
        ctrl.enable <= 1'b0;
        slow <= 1'b1;
        stall <= 1'b0;
        repeat (16) exp_q.push_back(v);
        drain();
        $display("test continuous done");
        close_out();
    end
endmodule
